// >>> rtl/dor_pkg.sv
// Purpose: Constants for the digital output routing block
// Assumes: Classic Wishbone register access, 32-bit data, 200 MHz clock
// Notes:   Names, codes and offsets shared by design and bench
// Contract
// - 16-bit entry: source high, gate low
// - Entry 0 soft PWM, entry 1 output 1
// - Entry bit 7 inverts the gating bit
// - All-ones entry disables routing for output
// - Code 00 drives one, 01 zero
// - Codes 02-08 encoder pulses divided 1..64
// - Codes 09-0F position pulses divided 1..64
// - Code 10 brake PWM, 11 inverted
// - Divider 1: one output edge per increment
// - Soft PWM to 2 kHz, others 500 Hz
// - Control bit 0 driven by brake control
// - Routing enabled overrides normal output configuration
`default_nettype none
package dor_pkg;
    localparam int          DOR_ENTRY_W     = 16;
    localparam logic [7:0]  DOR_SRC_ONE     = 8'h00;
    localparam logic [7:0]  DOR_SRC_ZERO    = 8'h01;
    localparam logic [7:0]  DOR_SRC_ENC_LO  = 8'h02;
    localparam logic [7:0]  DOR_SRC_ENC_HI  = 8'h08;
    localparam logic [7:0]  DOR_SRC_POS_LO  = 8'h09;
    localparam logic [7:0]  DOR_SRC_POS_HI  = 8'h0f;
    localparam logic [7:0]  DOR_SRC_PWM     = 8'h10;
    localparam logic [7:0]  DOR_SRC_PWM_INV = 8'h11;
    localparam int          DOR_INV_BIT     = 7;
    localparam logic [15:0] DOR_ENTRY_OFF   = 16'hffff;
    localparam logic [15:0] DOR_ENTRY_RST   = 16'hffff;
    // Register byte addresses
    localparam logic [7:0]  DOR_A_CTRL      = 8'h00;
    localparam logic [7:0]  DOR_A_OCW       = 8'h04;
    localparam logic [7:0]  DOR_A_POL       = 8'h08;
    localparam logic [7:0]  DOR_A_MAN_EN    = 8'h0c;
    localparam logic [7:0]  DOR_A_MAN_VAL   = 8'h10;
    localparam logic [7:0]  DOR_A_STATE     = 8'h14;
    localparam logic [7:0]  DOR_A_ENTRY0    = 8'h40;
    localparam int          DOR_CTRL_EN_BIT = 0;
    localparam int          DOR_OCW_OUT_LSB = 16;
    // Output frequency limits, Hz, and clock rate
    localparam longint      DOR_CLK_HZ      = 200000000;
    localparam longint      DOR_PWM_MAX_HZ  = 2000;
    localparam longint      DOR_OUT_MAX_HZ  = 500;
    // Least half period in cycles, rounded up
    localparam longint      DOR_PWM_HALF_CYC =
        (DOR_CLK_HZ + 2 * DOR_PWM_MAX_HZ - 1) / (2 * DOR_PWM_MAX_HZ);
    localparam longint      DOR_OUT_HALF_CYC =
        (DOR_CLK_HZ + 2 * DOR_OUT_MAX_HZ - 1) / (2 * DOR_OUT_MAX_HZ);
endpackage
`default_nettype wire

// >>> rtl/dor_chan.sv
// Purpose: One routed output channel: source select, divider, gating, rate limit
// Assumes: Pulse inputs are one-cycle strobes in the clock domain
// Notes:   Output changes no faster than the half period given by MIN_HALF
`timescale 1ns/100ps
`default_nettype none
module dor_chan import dor_pkg::*; #(
    parameter int MIN_HALF = 50000
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Configuration
    input  wire logic [15:0] entry_i,
    input  wire logic [31:0] ocw_i,
    // Sources
    input  wire logic        enc_inc_i,
    input  wire logic        pos_inc_i,
    input  wire logic        brake_pwm_i,
    // Result
    output logic             route_o
);
    typedef struct packed {
        logic [5:0]  div;
        logic        tgl;
        logic [31:0] hold;
        logic        out;
    } dor_chan_st_t;

    dor_chan_st_t s_reg;
    dor_chan_st_t s_next;

    logic [7:0] src;
    logic [7:0] gsel;
    logic       gate;
    logic       inc;
    logic [2:0] shamt;
    logic [6:0] ratio;
    logic       want;

    assign src  = entry_i[15:8];
    assign gsel = entry_i[7:0];
    assign gate = ocw_i[gsel[4:0]] ^ gsel[DOR_INV_BIT];

    always_comb begin
        s_next = s_reg;
        inc    = 1'b0;
        shamt  = 3'd0;
        want   = 1'b0;
        if (src >= DOR_SRC_ENC_LO && src <= DOR_SRC_ENC_HI) begin
            inc   = enc_inc_i;
            shamt = 3'(src - DOR_SRC_ENC_LO);
        end else if (src >= DOR_SRC_POS_LO && src <= DOR_SRC_POS_HI) begin
            inc   = pos_inc_i;
            shamt = 3'(src - DOR_SRC_POS_LO);
        end
        ratio = 7'd1 << shamt;
        if (inc) begin
            // One output edge each N increments
            if (7'(s_reg.div) + 7'd1 >= ratio) begin
                s_next.div = 6'd0;
                s_next.tgl = ~s_reg.tgl;
            end else begin
                s_next.div = s_reg.div + 6'd1;
            end
        end
        unique case (1'b1)
            (entry_i == DOR_ENTRY_OFF): want = 1'b0;
            (src == DOR_SRC_ONE):       want = 1'b1;
            (src == DOR_SRC_ZERO):      want = 1'b0;
            (src == DOR_SRC_PWM):       want = brake_pwm_i;
            (src == DOR_SRC_PWM_INV):   want = ~brake_pwm_i;
            (src >= DOR_SRC_ENC_LO && src <= DOR_SRC_POS_HI): want = s_reg.tgl;
            default:                    want = 1'b0;
        endcase
        if (entry_i != DOR_ENTRY_OFF) begin
            want = want & gate;
        end
        // Frequency limit: hold each level at least MIN_HALF cycles
        if (s_reg.hold != 32'd0) begin
            s_next.hold = s_reg.hold - 32'd1;
        end else if (want != s_reg.out) begin
            s_next.out  = want;
            s_next.hold = 32'(MIN_HALF - 1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign route_o = s_reg.out;
endmodule
`default_nettype wire

// >>> rtl/dor_top.sv
// Purpose: Digital output routing with Wishbone register access
// Assumes: Single clock, synchronous active-high reset
// Notes:   Open-drain pins: pin driven low when level is zero
`timescale 1ns/100ps
`default_nettype none
module dor_top import dor_pkg::*; #(
    parameter int NUM_OUT  = 4,
    parameter int PWM_HALF = int'(DOR_PWM_HALF_CYC),
    parameter int OUT_HALF = int'(DOR_OUT_HALF_CYC)
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // Wishbone slave
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [7:0]         adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    output logic [31:0]             dat_o,
    output logic                    ack_o,
    // Sources
    input  wire logic               enc_inc_i,
    input  wire logic               pos_inc_i,
    input  wire logic               brake_pwm_i,
    input  wire logic               brake_ctl_i,
    // Pins
    output logic                    soft_pwm_o,
    output logic [NUM_OUT-1:0]      out_o,
    output logic [NUM_OUT-1:0]      out_oe_o
);
    localparam int NE = NUM_OUT + 1;

    typedef struct packed {
        logic                   route_en;
        logic [31:0]            ocw;
        logic [NUM_OUT-1:0]     pol;
        logic [NUM_OUT-1:0]     man_en;
        logic [NUM_OUT-1:0]     man_val;
        logic [NE*16-1:0]       entry;
        logic [NE-1:0]          lvl;
        logic [NUM_OUT-1:0]     oe;
        logic [31:0]            dat;
        logic                   ack;
    } dor_st_t;

    dor_st_t          s_reg;
    dor_st_t          s_next;
    logic [NE-1:0]    route;
    logic [31:0]      ocw_eff;

    function automatic logic [31:0] wmask(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Brake control owns control bit 0
    assign ocw_eff = {s_reg.ocw[31:1], brake_ctl_i};

    genvar g;
    generate
        for (g = 0; g < NE; g++) begin : g_ch
            dor_chan #(
                .MIN_HALF (g == 0 ? PWM_HALF : OUT_HALF)
            ) u_ch (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .entry_i     (s_reg.entry[g*16 +: 16]),
                .ocw_i       (ocw_eff),
                .enc_inc_i   (enc_inc_i),
                .pos_inc_i   (pos_inc_i),
                .brake_pwm_i (brake_pwm_i),
                .route_o     (route[g])
            );
        end
    endgenerate

    always_comb begin
        logic [5:0] idx;
        logic [31:0] nv;
        idx    = 6'd0;
        nv     = 32'd0;
        s_next = s_reg;
        s_next.ack = 1'b0;
        if (cyc_i && stb_i && !s_reg.ack) begin
            s_next.ack = 1'b1;
            s_next.dat = 32'd0;
            if (adr_i >= DOR_A_ENTRY0 && adr_i < DOR_A_ENTRY0 + 8'(NE * 4)) begin
                idx = 6'((adr_i - DOR_A_ENTRY0) >> 2);
                s_next.dat = {16'd0, s_reg.entry[idx*16 +: 16]};
                if (we_i) begin
                    nv = wmask({16'd0, s_reg.entry[idx*16 +: 16]}, dat_i, sel_i);
                    s_next.entry[idx*16 +: 16] = nv[15:0];
                end
            end else begin
                unique case (adr_i)
                    DOR_A_CTRL: begin
                        s_next.dat = {31'd0, s_reg.route_en};
                        if (we_i && sel_i[0]) begin
                            s_next.route_en = dat_i[DOR_CTRL_EN_BIT];
                        end
                    end
                    DOR_A_OCW: begin
                        s_next.dat = ocw_eff;
                        if (we_i) begin
                            s_next.ocw = wmask(s_reg.ocw, dat_i, sel_i);
                        end
                    end
                    DOR_A_POL: begin
                        s_next.dat = 32'(s_reg.pol);
                        if (we_i) begin
                            nv = wmask(32'(s_reg.pol), dat_i, sel_i);
                            s_next.pol = nv[NUM_OUT-1:0];
                        end
                    end
                    DOR_A_MAN_EN: begin
                        s_next.dat = 32'(s_reg.man_en);
                        if (we_i) begin
                            nv = wmask(32'(s_reg.man_en), dat_i, sel_i);
                            s_next.man_en = nv[NUM_OUT-1:0];
                        end
                    end
                    DOR_A_MAN_VAL: begin
                        s_next.dat = 32'(s_reg.man_val);
                        if (we_i) begin
                            nv = wmask(32'(s_reg.man_val), dat_i, sel_i);
                            s_next.man_val = nv[NUM_OUT-1:0];
                        end
                    end
                    DOR_A_STATE: begin
                        s_next.dat = 32'(s_reg.lvl);
                    end
                    default: begin
                        s_next.dat = 32'd0;
                    end
                endcase
            end
        end
        // Output levels: routing or normal configuration
        if (s_reg.route_en) begin
            s_next.lvl = route;
        end else begin
            s_next.lvl[0] = 1'b0;
            for (int i = 0; i < NUM_OUT; i++) begin
                s_next.lvl[i+1] = s_reg.man_en[i] ? s_reg.man_val[i] :
                    (ocw_eff[DOR_OCW_OUT_LSB + i] ^ s_reg.pol[i]);
            end
        end
        // Open-drain enable registered beside the level it pulls low
        s_next.oe = ~s_next.lvl[NE-1:1];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg       <= '0;
            s_reg.entry <= {NE{DOR_ENTRY_RST}};
            s_reg.oe    <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dat_o      = s_reg.dat;
    assign ack_o      = s_reg.ack;
    assign soft_pwm_o = s_reg.lvl[0];
    assign out_o      = '0;
    assign out_oe_o   = s_reg.oe;
endmodule
`default_nettype wire

// >>> verif/dor_load.sv
// Purpose: External loads on the open-drain output pins
// Assumes: One pull-up resistor on every pin
// Notes:   A released pin reads high, a driven pin reads the data line
`timescale 1ns/100ps
`default_nettype none
module dor_load #(
    parameter int N = 4
) (
    // Pin drive from the block
    input  wire logic [N-1:0] out_i,
    input  wire logic [N-1:0] oe_i,
    // Level seen at the load
    output logic      [N-1:0] pin_o
);
    always_comb begin
        for (int i = 0; i < N; i++) begin
            pin_o[i] = oe_i[i] ? out_i[i] : 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> verif/dor_top_properties.sv
// Purpose: Port checks for the output routing block
// Assumes: Parameters equal those of the bound instance
// Notes:   Bound to every instance at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module dor_top_properties import dor_pkg::*; #(
    parameter int NUM_OUT  = 4,
    parameter int PWM_HALF = 4,
    parameter int OUT_HALF = 4
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // Register bus
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [7:0]         adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    input  wire logic [31:0]        dat_o,
    input  wire logic               ack_o,
    // Sources and pins
    input  wire logic               brake_ctl_i,
    input  wire logic               soft_pwm_o,
    input  wire logic [NUM_OUT-1:0] out_oe_o
);
    logic en_q;
    int   off_n;
    int   pwm_n;
    int   out_n;
    // Routing enable shadow, cycles with routing off, and cycles since soft PWM and output 1 last changed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q  <= 1'b0;
            off_n <= 1000;
            pwm_n <= 1000;
            out_n <= 1000;
        end else begin
            if (ack_o && we_i && adr_i == DOR_A_CTRL && sel_i[0]) begin
                en_q <= dat_i[0];
            end
            off_n <= en_q ? 0 : off_n + int'(off_n < 1000);
            pwm_n <= $changed(soft_pwm_o) ? 0 : pwm_n + int'(pwm_n < 1000);
            out_n <= $changed(out_oe_o[0]) ? 0 : out_n + int'(out_n < 1000);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////////////
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !soft_pwm_o && &out_oe_o)
        else $error("outputs active out of reset");
    a_unmapped_zero: assert property (ack_o && !we_i && adr_i inside {[8'h18:8'h3c]}
        |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_ocw_brake: assert property (ack_o && !we_i && adr_i == DOR_A_OCW
        |-> dat_o[0] == $past(brake_ctl_i))
        else $error("control bit 0 not brake control");
    a_pwm_hold: assert property ($changed(soft_pwm_o) |-> pwm_n >= PWM_HALF - 1)
        else $error("soft pwm level too short");
    a_out_hold: assert property ($changed(out_oe_o[0]) |-> out_n >= OUT_HALF - 1)
        else $error("output level too short");
    a_route_off: assert property (off_n >= PWM_HALF + 6 |-> !soft_pwm_o)
        else $error("soft pwm active with routing off");
    c_write: cover property (ack_o && we_i);
    c_pwm_rise: cover property ($rose(soft_pwm_o));
    c_out_move: cover property ($changed(out_oe_o));
endmodule
bind dor_top dor_top_properties #(.NUM_OUT(NUM_OUT), .PWM_HALF(PWM_HALF), .OUT_HALF(OUT_HALF))
    i_dor_top_properties (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .brake_ctl_i(brake_ctl_i), .soft_pwm_o(soft_pwm_o), .out_oe_o(out_oe_o));
`default_nettype wire

// >>> verif/dor_top_bench.sv
// Purpose: Self-checking bench for the output routing block
// Assumes: Short level hold parameters keep the run brief
// Notes:   Static sources by table, dividers and edge cases by hand
`timescale 1ns/100ps
`default_nettype none
module dor_top_bench import dor_pkg::*;;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, last;
    logic        enc_inc_i, pos_inc_i, brake_pwm_i, brake_ctl_i, soft_pwm_o;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic [1:0]  out_o, out_oe_o, pin;
    logic [26:0] r;
    int          failures, total_checks, i, k, p, tg, ch;
    // Entry, control byte, brake pwm, brake control, expected soft pwm level
    logic [26:0] rows [13] = '{{16'h0005, 8'h20, 3'b001}, {16'h0005, 8'h00, 3'b000},
        {16'h0085, 8'h00, 3'b001}, {16'h0085, 8'h20, 3'b000}, {16'h0105, 8'h20, 3'b000},
        {16'h1005, 8'h20, 3'b101}, {16'h1005, 8'h20, 3'b000}, {16'h1105, 8'h20, 3'b100},
        {16'h1105, 8'h20, 3'b001}, {16'hffff, 8'h20, 3'b100}, {16'h2005, 8'h20, 3'b100},
        {16'h1080, 8'h00, 3'b101}, {16'h1080, 8'h00, 3'b110}};
    dor_top #(.NUM_OUT(2), .PWM_HALF(4), .OUT_HALF(4)) i_dor_top (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .enc_inc_i(enc_inc_i),
        .pos_inc_i(pos_inc_i), .brake_pwm_i(brake_pwm_i), .brake_ctl_i(brake_ctl_i),
        .soft_pwm_o(soft_pwm_o), .out_o(out_o), .out_oe_o(out_oe_o));
    dor_load #(.N(2)) i_dor_load (.out_i(out_o), .oe_i(out_oe_o), .pin_o(pin));
    always #2.5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        rd = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        if (n >= 40) failures++;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        failures++;
        report_and_stop();
    end
    initial begin
        {clk_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
        {enc_inc_i, pos_inc_i, brake_pwm_i, brake_ctl_i} = '0;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, DOR_A_ENTRY0, 32'h0, q);
        chk("entry reset", 32'hffff, {16'h0, q[15:0]});
        wb(1'b0, DOR_A_CTRL, 32'h0, q);
        chk("enable reset", 32'h0, {31'h0, q[0]});
        wb(1'b1, DOR_A_MAN_EN, 32'hffffffff, q);
        wb(1'b1, DOR_A_MAN_VAL, 32'h0, q);
        wb(1'b1, DOR_A_CTRL, 32'h1, q);
        for (i = 0; i < 13; i++) begin
            r = rows[i];
            brake_pwm_i <= r[2];
            brake_ctl_i <= r[1];
            wb(1'b1, DOR_A_ENTRY0, {16'h0, r[26:11]}, q);
            wb(1'b1, DOR_A_OCW, {24'h0, r[10:3]}, q);
            repeat (12) @(posedge clk_i);
            chk("soft pwm", {31'h0, r[0]}, {31'h0, soft_pwm_o});
        end
        wb(1'b1, 8'h20, 32'h5a5a5a5a, q);
        wb(1'b0, 8'h20, 32'h0, q);
        chk("unmapped", 32'h0, q);
        brake_ctl_i <= 1'b1;
        wb(1'b0, DOR_A_OCW, 32'h0, q);
        chk("control bit 0", 32'h1, {31'h0, q[0]});
        wb(1'b1, DOR_A_OCW, 32'h20, q);
        // Count increments between the second and third pin edges
        for (i = 0; i < 14; i++) begin
            ch = int'(i >= 7);
            wb(1'b1, DOR_A_ENTRY0 + 8'h04 + 8'(4 * ch), {16'h0, 8'(8'h02 + i), 8'h05}, q);
            repeat (12) @(posedge clk_i);
            last = pin[ch];
            {tg, k, p} = '0;
            while (tg < 3 && k < 300) begin
                @(posedge clk_i);
                {enc_inc_i, pos_inc_i} <= {ch == 0, ch == 1};
                @(posedge clk_i);
                {enc_inc_i, pos_inc_i} <= 2'b00;
                repeat (10) @(posedge clk_i);
                k++;
                if (pin[ch] !== last) begin
                    last = pin[ch];
                    tg++;
                    if (tg == 2) p = k;
                end
            end
            chk("divider gap", 32'(1 << (i % 7)), 32'(k - p));
        end
        // Both routed levels high before routing goes off
        wb(1'b1, DOR_A_ENTRY0, 32'h0005, q);
        wb(1'b1, DOR_A_ENTRY0 + 8'h04, 32'h0005, q);
        repeat (12) @(posedge clk_i);
        chk("soft pwm on", 32'h1, {31'h0, soft_pwm_o});
        chk("pin routed", 32'h1, {31'h0, pin[0]});
        wb(1'b0, DOR_A_STATE, 32'h0, q);
        chk("state routed", 32'h3, {30'h0, q[1:0]});
        wb(1'b1, DOR_A_CTRL, 32'h0, q);
        repeat (12) @(posedge clk_i);
        chk("soft pwm off", 32'h0, {31'h0, soft_pwm_o});
        chk("pin manual", 32'h0, {31'h0, pin[0]});
        // Normal configuration: output 1 from control bit 16, output 2 inverted
        wb(1'b1, DOR_A_MAN_EN, 32'h0, q);
        wb(1'b1, DOR_A_POL, 32'h2, q);
        wb(1'b1, DOR_A_OCW, 32'h10020, q);
        repeat (4) @(posedge clk_i);
        chk("pin normal 1", 32'h1, {31'h0, pin[0]});
        chk("pin normal 2", 32'h1, {31'h0, pin[1]});
        wb(1'b0, DOR_A_STATE, 32'h0, q);
        chk("state normal", 32'h6, {29'h0, q[2:0]});
        // Reset in mid-run
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, DOR_A_ENTRY0 + 8'h04, 32'h0, q);
        chk("entry after reset", 32'hffff, {16'h0, q[15:0]});
        chk("pin after reset", 32'h0, {31'h0, pin[0]});
        report_and_stop();
    end
endmodule
`default_nettype wire
